// ---- common/sdm_consts.svh ----
// constants for the stack depth monitor: offsets, fields, reset values
// assumes a byte-wide register port with a 4-bit address
//
// Summary of operation
// - depth lives in a 6-bit counter, low six bits of the stack register
// - counter steps up on call, internal or external interrupt entry
// - counter steps down on subroutine return or interrupt return
// - counter code is plain binary, code n means level n
// - bit 6 of the stack register masks the overflow interrupt
// - bit 7 of the stack register holds the overflow flag
// - flag sets on the step from 30 to 31, whatever the mask
// - with mask set, that step raises the overflow interrupt request
`ifndef SDM_CONSTS_SVH
`define SDM_CONSTS_SVH

// register offsets
`define SDM_REG_STACK 4'h0
`define SDM_REG_CTRL 4'h1
`define SDM_REG_INT_STAT 4'h2
`define SDM_REG_INT_MASK 4'h3
`define SDM_REG_PEAK 4'h4

// stack register fields
`define SDM_BIT_FLAG 7
`define SDM_BIT_MASK 6
`define SDM_CNT_MSB 5
`define SDM_CNT_LSB 0

// control register fields
`define SDM_CTRL_EN 0

// interrupt status and mask fields
`define SDM_INT_OVF 0
`define SDM_INT_WRAP 1
`define SDM_INT_UNDER 2
`define SDM_INT_MSB 2

// counter codes
`define SDM_OVF_FROM 6'h1e
`define SDM_CNT_ZERO 6'h00
`define SDM_CNT_MAX 6'h3f
`define SDM_CNT_ONE 6'h01

// reset values
`define SDM_RST_BYTE 8'h00
`define SDM_RST_INT 3'h0

`endif

// ---- common/sdm_pkg.sv ----
// types shared by the stack depth monitor files
// assumes sdm_consts.svh for all numeric constants
package sdm_pkg;

  typedef logic [7:0] sdm_byte_t;
  typedef logic [5:0] sdm_depth_t;
  typedef logic [2:0] sdm_int_t;

  typedef struct packed {
    logic [3:0] addr;
    sdm_byte_t wdata;
    logic wr;
    logic rd;
  } sdm_bus_req_s;

  typedef struct packed {
    logic call_instruction;
    logic internal_interrupt;
    logic external_interrupt;
    logic subroutine_return_instruction;
    logic interrupt_return_instruction;
  } sdm_evt_s;

  typedef enum logic [1:0] {
    SDM_HOLD,
    SDM_PUSH,
    SDM_POP
  } sdm_step_e;

endpackage

// ---- rtl/sdm_depth_ctr.sv ----
// 6-bit up/down depth counter with step event outputs
// assumes one-cycle push/pop pulses from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "sdm_consts.svh"

module sdm_depth_ctr
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_en,
  input wire logic i_up,
  input wire logic i_down,
  output sdm_pkg::sdm_depth_t o_count,
  output logic o_ovf_step,
  output logic o_wrap,
  output logic o_under
);
  import sdm_pkg::*;

  sdm_step_e step;
  sdm_depth_t count;
  sdm_depth_t next_count;

  // push and pop together cancel out
  always_comb
  begin
    if (!i_en)
      step = SDM_HOLD;
    else if (i_up && !i_down)
      step = SDM_PUSH;
    else if (i_down && !i_up)
      step = SDM_POP;
    else
      step = SDM_HOLD;
  end

  always_comb
  begin
    case (step)
      SDM_PUSH: next_count = count + `SDM_CNT_ONE;
      SDM_POP: next_count = count - `SDM_CNT_ONE;
      default: next_count = count;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      count <= `SDM_CNT_ZERO;
    else
      count <= next_count;
  end

  assign o_count = count;
  // pulses in the cycle whose edge makes the step
  assign o_ovf_step = (step == SDM_PUSH) && (count == `SDM_OVF_FROM);
  assign o_wrap = (step == SDM_PUSH) && (count == `SDM_CNT_MAX);
  assign o_under = (step == SDM_POP) && (count == `SDM_CNT_ZERO);

endmodule // sdm_depth_ctr

`default_nettype wire

// ---- rtl/sdm_top.sv ----
// stack depth monitor: depth counter, overflow flag, register port, irq
// assumes core event pulses on i_mclk, one cycle each, at most one push
// and one pop source per cycle; register reads answer one cycle later
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sdm_consts.svh"

module sdm_top
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire sdm_pkg::sdm_bus_req_s i_bus,
  output sdm_pkg::sdm_byte_t o_rdata,
  input wire sdm_pkg::sdm_evt_s i_evt,
  output sdm_pkg::sdm_depth_t o_depth,
  output logic o_stk_irq,
  output logic o_irq
);
  import sdm_pkg::*;

  // address hit for a strobe
  function automatic logic hit
  (
    input logic strobe,
    input logic [3:0] addr,
    input logic [3:0] target
  );
    hit = strobe && (addr == target);
  endfunction

  // new sticky value: set wins over write-one-to-clear
  function automatic sdm_int_t sticky
  (
    input sdm_int_t cur,
    input sdm_int_t set,
    input sdm_int_t clr
  );
    sticky = (cur & ~clr) | set;
  endfunction

  logic wr_stack;
  logic wr_ctrl;
  logic wr_istat;
  logic wr_imask;
  logic wr_peak;
  logic rd_stack;
  logic rd_ctrl;
  logic rd_istat;
  logic rd_imask;
  logic rd_peak;

  logic count_en;
  logic ovf_flag;
  logic ovf_mask;
  sdm_int_t int_stat;
  sdm_int_t int_mask;
  sdm_int_t int_set;
  sdm_depth_t peak;
  sdm_byte_t rdata;
  sdm_byte_t next_rdata;

  logic push;
  logic pop;
  sdm_depth_t depth;
  logic ovf_step;
  logic wrap;
  logic under;

  // register decode
  always_comb
  begin
    wr_stack = hit(i_bus.wr, i_bus.addr, `SDM_REG_STACK);
    wr_ctrl = hit(i_bus.wr, i_bus.addr, `SDM_REG_CTRL);
    wr_istat = hit(i_bus.wr, i_bus.addr, `SDM_REG_INT_STAT);
    wr_imask = hit(i_bus.wr, i_bus.addr, `SDM_REG_INT_MASK);
    wr_peak = hit(i_bus.wr, i_bus.addr, `SDM_REG_PEAK);
    rd_stack = hit(i_bus.rd, i_bus.addr, `SDM_REG_STACK);
    rd_ctrl = hit(i_bus.rd, i_bus.addr, `SDM_REG_CTRL);
    rd_istat = hit(i_bus.rd, i_bus.addr, `SDM_REG_INT_STAT);
    rd_imask = hit(i_bus.rd, i_bus.addr, `SDM_REG_INT_MASK);
    rd_peak = hit(i_bus.rd, i_bus.addr, `SDM_REG_PEAK);
  end

  // core sequencing events
  always_comb
  begin
    push = i_evt.call_instruction
      || i_evt.internal_interrupt
      || i_evt.external_interrupt;
    pop = i_evt.subroutine_return_instruction
      || i_evt.interrupt_return_instruction;
  end

  sdm_depth_ctr u_ctr
  (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_en(count_en),
    .i_up(push),
    .i_down(pop),
    .o_count(depth),
    .o_ovf_step(ovf_step),
    .o_wrap(wrap),
    .o_under(under)
  );

  // counting stays off until software turns it on
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      count_en <= 1'b0;
    else if (wr_ctrl)
      count_en <= i_bus.wdata[`SDM_CTRL_EN];
  end

  // overflow mask, plain read/write
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      ovf_mask <= 1'b0;
    else if (wr_stack)
      ovf_mask <= i_bus.wdata[`SDM_BIT_MASK];
  end

  // overflow flag: writing 1 leaves it, writing 0 clears it;
  // a step in the same cycle as the clear keeps it set
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      ovf_flag <= 1'b0;
    else if (ovf_step)
      ovf_flag <= 1'b1;
    else if (wr_stack && !i_bus.wdata[`SDM_BIT_FLAG])
      ovf_flag <= 1'b0;
  end

  // sticky event bits for the general interrupt
  always_comb
  begin
    int_set = `SDM_RST_INT;
    int_set[`SDM_INT_OVF] = ovf_step;
    int_set[`SDM_INT_WRAP] = wrap;
    int_set[`SDM_INT_UNDER] = under;
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      int_stat <= `SDM_RST_INT;
    else if (wr_istat)
      int_stat <= sticky(int_stat, int_set,
        i_bus.wdata[`SDM_INT_MSB:0]);
    else
      int_stat <= int_stat | int_set;
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      int_mask <= `SDM_RST_INT;
    else if (wr_imask)
      int_mask <= i_bus.wdata[`SDM_INT_MSB:0];
  end

  // high-water mark; any write restarts it from the live depth
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      peak <= `SDM_CNT_ZERO;
    else if (wr_peak)
      peak <= depth;
    else if (depth > peak)
      peak <= depth;
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = `SDM_RST_BYTE;
    if (rd_stack)
    begin
      next_rdata[`SDM_BIT_FLAG] = ovf_flag;
      next_rdata[`SDM_BIT_MASK] = ovf_mask;
      next_rdata[`SDM_CNT_MSB:`SDM_CNT_LSB] = depth;
    end
    else if (rd_ctrl)
    begin
      next_rdata[`SDM_CTRL_EN] = count_en;
    end
    else if (rd_istat)
    begin
      next_rdata[`SDM_INT_MSB:0] = int_stat;
    end
    else if (rd_imask)
    begin
      next_rdata[`SDM_INT_MSB:0] = int_mask;
    end
    else if (rd_peak)
    begin
      next_rdata[`SDM_CNT_MSB:`SDM_CNT_LSB] = peak;
    end
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata <= `SDM_RST_BYTE;
    else
      rdata <= next_rdata;
  end

  assign o_rdata = rdata;
  assign o_depth = depth;
  // level from flops, no pulse: core samples it at its own pace
  assign o_stk_irq = ovf_flag && ovf_mask;
  assign o_irq = |(int_stat & int_mask);

endmodule // sdm_top

`default_nettype wire

// ---- tb/sdm_props.sv ----
// checker on the stack depth monitor top ports
// assumes bind to sdm_top; enable and mask mirrored from bus writes
`timescale 1ns/1ps
`default_nettype none
module sdm_props
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire sdm_pkg::sdm_bus_req_s i_bus,
  input wire sdm_pkg::sdm_byte_t o_rdata,
  input wire sdm_pkg::sdm_evt_s i_evt,
  input wire sdm_pkg::sdm_depth_t o_depth,
  input wire logic o_stk_irq,
  input wire logic o_irq
);
  import sdm_pkg::*;
  logic en;
  logic msk;
  wire logic psh = |i_evt[4:2];
  wire logic pop = |i_evt[1:0];
  wire logic wr0 = i_bus.wr && i_bus.addr == 4'h0;
  // shadow copies, since the checker cannot see inside
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      en <= 1'b0;
      msk <= 1'b0;
    end
    else if (i_bus.wr && i_bus.addr == 4'h1)
      en <= i_bus.wdata[0];
    else if (wr0)
      msk <= i_bus.wdata[6];
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  push_step_a: assert property (
    en && psh && !pop |=> o_depth == $past(o_depth) + 6'h01)
    else $error("depth up");
  pop_step_a: assert property (
    en && pop && !psh |=> o_depth == $past(o_depth) - 6'h01)
    else $error("depth down");
  depth_hold_a: assert property (
    !en || psh == pop |=> $stable(o_depth)) else $error("depth hold");
  ovf_irq_a: assert property (
    en && psh && !pop && msk && !wr0 && o_depth == 6'h1e |=> o_stk_irq)
    else $error("ovf irq");
  irq_mask_a: assert property (
    !msk |-> !o_stk_irq) else $error("irq unmasked");
  irq_hold_a: assert property (
    o_stk_irq && !wr0 |=> o_stk_irq) else $error("irq hold");
  read_depth_a: assert property (
    i_bus.rd && i_bus.addr == 4'h0
    |=> o_rdata[6:0] == {$past(msk), $past(o_depth)})
    else $error("read depth");
  rdata_idle_a: assert property (
    !i_bus.rd |=> o_rdata == 8'h00) else $error("rdata idle");
endmodule // sdm_props
bind sdm_top sdm_props i_props (.i_mclk, .i_nrst, .i_bus, .o_rdata,
  .i_evt, .o_depth, .o_stk_irq, .o_irq);
`default_nettype wire

// ---- tb/sdm_core_model.sv ----
// core side: call, interrupt and return event pulses
// assumes the bench calls fire from its main thread
`timescale 1ns/1ps
`default_nettype none
module sdm_core_model
(
  input wire logic i_mclk,
  output sdm_pkg::sdm_evt_s o_evt
);
  import sdm_pkg::*;
  initial o_evt = '0;
  // g idle cycles between pulses mimic a slow core
  task automatic fire(input logic [4:0] v, input int n, input int g);
    repeat (n)
    begin
      @(posedge i_mclk);
      o_evt <= v;
      repeat (g)
      begin
        @(posedge i_mclk);
        o_evt <= '0;
      end
    end
    @(posedge i_mclk);
    o_evt <= '0;
    #1;
  endtask
endmodule // sdm_core_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the stack depth monitor
// assumes sdm_top, sdm_core_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sdm_pkg::*;
  logic i_mclk;
  logic i_nrst;
  sdm_bus_req_s bus;
  sdm_byte_t rdata;
  sdm_evt_s evt;
  sdm_depth_t depth;
  logic stk_irq;
  logic irq;
  int errors;
  int checks;
  sdm_top i_dut (.i_mclk, .i_nrst, .i_bus(bus), .o_rdata(rdata),
    .i_evt(evt), .o_depth(depth), .o_stk_irq(stk_irq), .o_irq(irq));
  sdm_core_model i_core (.i_mclk, .o_evt(evt));
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_mclk);
    bus <= '0;
    #1;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_mclk);
    bus <= '0;
    #1 chk("rdata", e, rdata);
  endtask
  task rst;
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
  endtask
  task stop_test;
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task t_regs;
    rd(4'h0, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
  endtask
  // counting stays off until software enables it
  task t_off;
    i_core.fire(5'h10, 2, 0);
    chk("depth", 8'h00, {2'b00, depth});
  endtask
  task t_count;
    wr(4'h1, 8'h01);
    rd(4'h1, 8'h01);
    i_core.fire(5'h08, 1, 0);
    i_core.fire(5'h04, 1, 1);
    i_core.fire(5'h10, 1, 0);
    chk("depth", 8'h03, {2'b00, depth});
    rd(4'h4, 8'h03);
    i_core.fire(5'h11, 1, 0);
    chk("depth", 8'h03, {2'b00, depth});
    i_core.fire(5'h02, 1, 0);
    i_core.fire(5'h01, 1, 2);
    rd(4'h0, 8'h01);
  endtask
  task t_ovf;
    i_core.fire(5'h10, 29, 0);
    rd(4'h0, 8'h1e);
    i_core.fire(5'h10, 1, 0);
    rd(4'h0, 8'h9f);
    chk("stk_irq", 8'h00, {7'h00, stk_irq});
    wr(4'h0, 8'h40);
    rd(4'h0, 8'h5f);
    i_core.fire(5'h01, 1, 0);
    i_core.fire(5'h10, 1, 0);
    chk("stk_irq", 8'h01, {7'h00, stk_irq});
    rd(4'h0, 8'hdf);
    wr(4'h0, 8'hc0);
    chk("stk_irq", 8'h01, {7'h00, stk_irq});
    wr(4'h0, 8'h40);
    chk("stk_irq", 8'h00, {7'h00, stk_irq});
    i_core.fire(5'h10, 1, 0);
    rd(4'h0, 8'h60);
    rd(4'h2, 8'h01);
    wr(4'h3, 8'h01);
    chk("irq", 8'h01, {7'h00, irq});
    wr(4'h2, 8'h01);
    chk("irq", 8'h00, {7'h00, irq});
  endtask
  // modulo 64 both ways; reset mid-run first
  task t_wrap;
    rst;
    wr(4'h1, 8'h01);
    wr(4'h3, 8'h06);
    rd(4'h3, 8'h06);
    i_core.fire(5'h02, 1, 0);
    rd(4'h0, 8'h3f);
    chk("irq", 8'h01, {7'h00, irq});
    rd(4'h4, 8'h3f);
    i_core.fire(5'h10, 1, 0);
    chk("depth", 8'h00, {2'b00, depth});
    rd(4'h2, 8'h06);
    wr(4'h4, 8'h00);
    rd(4'h4, 8'h00);
  endtask
  initial
  begin
    i_nrst = 1'b0;
    bus = '0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_regs;
    t_off;
    t_count;
    t_ovf;
    t_wrap;
    stop_test;
  end
  // run needs about 120 cycles
  initial
  begin
    #50000;
    errors++;
    stop_test;
  end
endmodule // testbench
`default_nettype wire
